// File: rtl/ueb_consts.vh
// Function
// - start when capacitive power exceeds setting
// - trip after start outlasts operate delay
// - power from fundamental currents, line voltages
// - pick up left of line, Q negative
// - first point at zero active power
// - second point at 80 percent power
// - short interruptions keep accumulating fault time
`ifndef UEB_CONSTS_VH
`define UEB_CONSTS_VH
// register byte offsets
`define UEB_ADR_CTRL      8'h00
`define UEB_ADR_Q_ZERO    8'h04
`define UEB_ADR_Q_HIGH    8'h08
`define UEB_ADR_OP_DLY    8'h0C
`define UEB_ADR_RLS_DLY   8'h10
`define UEB_ADR_STATUS    8'h14
`define UEB_ADR_PQ        8'h18
`define UEB_ADR_ELAPSED   8'h1C
// control fields
`define UEB_CTRL_EN_BIT   0
`define UEB_CTRL_SH_LSB   8
`define UEB_CTRL_SH_MSB   12
// status fields
`define UEB_ST_AREA_BIT   0
`define UEB_ST_START_BIT  1
`define UEB_ST_TRIP_BIT   2
// reset values
`define UEB_RST_CTRL      32'h0000_0001
`define UEB_RST_Q_ZERO    16'hFE0C
`define UEB_RST_Q_HIGH    16'hFE0C
`define UEB_RST_OP_DLY    16'h03E8
`define UEB_RST_RLS_DLY   16'h0000
// power scale: 0.1 percent units, rated power is 1000
`define UEB_P_HIGH_POINT  40'sh00_0000_0320
`define UEB_P_ZERO_POINT  40'sh00_0000_0000
// timing: one millisecond tick at 20 MHz
`define UEB_CLK_HZ        20000000
`define UEB_TICK_MS       1
`define UEB_TICK_CYCLES   ((`UEB_CLK_HZ / 1000) * `UEB_TICK_MS)
`endif

// File: rtl/ueb_power.v
`timescale 1ns/10ps
`include "ueb_consts.vh"
module ueb_power (
  // clock and reset
  input  wire               clk_i,
  input  wire               rst_i,
  // fundamental phasors
  input  wire               meas_valid_i,
  input  wire signed [15:0] u12_re_i,
  input  wire signed [15:0] u12_im_i,
  input  wire signed [15:0] u23_re_i,
  input  wire signed [15:0] u23_im_i,
  input  wire signed [15:0] i1_re_i,
  input  wire signed [15:0] i1_im_i,
  input  wire signed [15:0] i3_re_i,
  input  wire signed [15:0] i3_im_i,
  // scaling
  input  wire        [4:0]  shift_i,
  // scaled power
  output reg                pq_valid_o,
  output reg  signed [15:0] p_o,
  output reg  signed [15:0] q_o
);

  function signed [15:0] sat16;
    input signed [33:0] v;
    begin
      if (v > 34'sd32767) begin
        sat16 = 16'sh7FFF;
      end else if (v < -34'sd32768) begin
        sat16 = 16'sh8000;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  // two-wattmeter complex power: u12*conj(i1) - u23*conj(i3)
  wire signed [33:0] p_raw;
  wire signed [33:0] q_raw;
  assign p_raw = $signed({{2{1'b0}}, 32'h0000_0000}) + u12_re_i * i1_re_i + u12_im_i * i1_im_i
                 - u23_re_i * i3_re_i - u23_im_i * i3_im_i;
  assign q_raw = $signed({{2{1'b0}}, 32'h0000_0000}) + u12_im_i * i1_re_i - u12_re_i * i1_im_i
                 - u23_im_i * i3_re_i + u23_re_i * i3_im_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pq_valid_o <= 1'b0;
      p_o        <= 16'sh0000;
      q_o        <= 16'sh0000;
    end else begin
      pq_valid_o <= meas_valid_i;
      if (meas_valid_i) begin
        p_o <= sat16(p_raw >>> shift_i);
        q_o <= sat16(q_raw >>> shift_i);
      end
    end
  end

endmodule // ueb_power

// File: rtl/ueb_stage.v
`timescale 1ns/10ps
`include "ueb_consts.vh"
module ueb_stage #(
  parameter TICK_CYCLES = `UEB_TICK_CYCLES
) (
  // clock and reset
  input  wire               clk_i,
  input  wire               rst_i,
  // wishbone slave
  input  wire               cyc_i,
  input  wire               stb_i,
  input  wire               we_i,
  input  wire        [7:0]  adr_i,
  input  wire        [3:0]  sel_i,
  input  wire        [31:0] dat_i,
  output reg         [31:0] dat_o,
  output reg                ack_o,
  // fundamental phasors
  input  wire               meas_valid_i,
  input  wire signed [15:0] u12_re_i,
  input  wire signed [15:0] u12_im_i,
  input  wire signed [15:0] u23_re_i,
  input  wire signed [15:0] u23_im_i,
  input  wire signed [15:0] i1_re_i,
  input  wire signed [15:0] i1_im_i,
  input  wire signed [15:0] i3_re_i,
  input  wire signed [15:0] i3_im_i,
  // stage outputs
  output wire               start_o,
  output wire               trip_o
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg         [31:0] ctrl_reg;
  reg  signed [15:0] q_zero_reg;
  reg  signed [15:0] q_high_reg;
  reg         [15:0] op_dly_reg;
  reg         [15:0] rls_dly_reg;
  reg                area_reg;
  reg                start_reg;
  reg                trip_reg;
  reg         [15:0] acc_reg;
  reg         [15:0] rls_cnt_reg;
  reg         [14:0] tick_cnt_reg;
  reg                tick_reg;

  wire               pq_valid;
  wire signed [15:0] p_meas;
  wire signed [15:0] q_meas;
  wire               enable;
  wire               wb_req;
  wire               wb_wr;
  reg         [31:0] wr_old;
  wire        [31:0] wr_merged;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] new_val;
    input [3:0]  sel;
    integer      k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  ueb_power u_power (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .meas_valid_i (meas_valid_i),
    .u12_re_i     (u12_re_i),
    .u12_im_i     (u12_im_i),
    .u23_re_i     (u23_re_i),
    .u23_im_i     (u23_im_i),
    .i1_re_i      (i1_re_i),
    .i1_im_i      (i1_im_i),
    .i3_re_i      (i3_re_i),
    .i3_im_i      (i3_im_i),
    .shift_i      (ctrl_reg[`UEB_CTRL_SH_MSB:`UEB_CTRL_SH_LSB]),
    .pq_valid_o   (pq_valid),
    .p_o          (p_meas),
    .q_o          (q_meas)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  assign enable = ctrl_reg[`UEB_CTRL_EN_BIT];
  assign wb_req = cyc_i & stb_i & ~ack_o;
  assign wb_wr  = wb_req & we_i;

  // current word of the addressed register, for byte merging
  always @* begin
    case (adr_i)
      `UEB_ADR_CTRL:    wr_old = ctrl_reg;
      `UEB_ADR_Q_ZERO:  wr_old = {16'h0000, q_zero_reg};
      `UEB_ADR_Q_HIGH:  wr_old = {16'h0000, q_high_reg};
      `UEB_ADR_OP_DLY:  wr_old = {16'h0000, op_dly_reg};
      `UEB_ADR_RLS_DLY: wr_old = {16'h0000, rls_dly_reg};
      default:          wr_old = 32'h0000_0000;
    endcase
  end

  assign wr_merged = merge(wr_old, dat_i, sel_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o       <= 1'b0;
      dat_o       <= 32'h0000_0000;
      ctrl_reg    <= `UEB_RST_CTRL;
      q_zero_reg  <= `UEB_RST_Q_ZERO;
      q_high_reg  <= `UEB_RST_Q_HIGH;
      op_dly_reg  <= `UEB_RST_OP_DLY;
      rls_dly_reg <= `UEB_RST_RLS_DLY;
    end else begin
      ack_o <= wb_req;
      if (wb_wr) begin
        case (adr_i)
          `UEB_ADR_CTRL: begin
            ctrl_reg <= wr_merged & 32'h0000_1F01;
          end
          `UEB_ADR_Q_ZERO: begin
            q_zero_reg <= wr_merged[15:0];
          end
          `UEB_ADR_Q_HIGH: begin
            q_high_reg <= wr_merged[15:0];
          end
          `UEB_ADR_OP_DLY: begin
            op_dly_reg <= wr_merged[15:0];
          end
          `UEB_ADR_RLS_DLY: begin
            rls_dly_reg <= wr_merged[15:0];
          end
          default: begin
          end
        endcase
      end
      if (wb_req & ~we_i) begin
        case (adr_i)
          `UEB_ADR_CTRL:    dat_o <= ctrl_reg;
          `UEB_ADR_Q_ZERO:  dat_o <= {16'h0000, q_zero_reg};
          `UEB_ADR_Q_HIGH:  dat_o <= {16'h0000, q_high_reg};
          `UEB_ADR_OP_DLY:  dat_o <= {16'h0000, op_dly_reg};
          `UEB_ADR_RLS_DLY: dat_o <= {16'h0000, rls_dly_reg};
          `UEB_ADR_STATUS:  dat_o <= {29'h0000_0000, trip_reg, start_reg, area_reg};
          `UEB_ADR_PQ:      dat_o <= {p_meas, q_meas};
          `UEB_ADR_ELAPSED: dat_o <= {16'h0000, acc_reg};
          default:          dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trip area: q*800 < q_zero*800 + (q_high - q_zero)*p, q < 0
  wire signed [39:0] lhs;
  wire signed [39:0] rhs;
  wire               in_area;
  assign lhs = $signed({{24{q_meas[15]}}, q_meas}) * (`UEB_P_HIGH_POINT - `UEB_P_ZERO_POINT);
  assign rhs = $signed({{24{q_zero_reg[15]}}, q_zero_reg}) * (`UEB_P_HIGH_POINT - `UEB_P_ZERO_POINT)
             + ($signed({{24{q_high_reg[15]}}, q_high_reg}) - $signed({{24{q_zero_reg[15]}}, q_zero_reg}))
             * $signed({{24{p_meas[15]}}, p_meas});
  assign in_area = (lhs < rhs) && q_meas[15];

  always @(posedge clk_i) begin
    if (rst_i) begin
      area_reg <= 1'b0;
    end else if (!enable) begin
      area_reg <= 1'b0;
    end else if (pq_valid) begin
      area_reg <= in_area;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 15'h0000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_CYCLES[14:0] - 15'h0001) begin
      tick_cnt_reg <= 15'h0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 15'h0001;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start, trip and release timing
  always @(posedge clk_i) begin
    if (rst_i || !enable) begin
      start_reg   <= 1'b0;
      trip_reg    <= 1'b0;
      acc_reg     <= 16'h0000;
      rls_cnt_reg <= 16'h0000;
    end else if (area_reg) begin
      start_reg   <= 1'b1;
      rls_cnt_reg <= 16'h0000;
      if (tick_reg && acc_reg != 16'hFFFF) begin
        acc_reg <= acc_reg + 16'h0001;
      end
      if (acc_reg > op_dly_reg) begin
        trip_reg <= 1'b1;
      end
    end else if (start_reg && tick_reg) begin
      if (rls_cnt_reg >= rls_dly_reg) begin
        start_reg   <= 1'b0;
        trip_reg    <= 1'b0;
        acc_reg     <= 16'h0000;
        rls_cnt_reg <= 16'h0000;
      end else begin
        rls_cnt_reg <= rls_cnt_reg + 16'h0001;
      end
    end
  end

  assign start_o = start_reg;
  assign trip_o  = trip_reg;

endmodule // ueb_stage

// File: verification/ueb_stage_assertions.sv
`timescale 1ns/10ps
module ueb_stage_assertions (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // stage
  input wire logic        meas_valid_i,
  input wire logic        start_o,
  input wire logic        trip_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_status_read;
    s_take ##0 (!we_i && adr_i == 8'h14);
  endsequence
  chk_ack_answer: assert property (s_take |=> ack_o) else $error("no ack");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  chk_status_mirror: assert property (s_status_read |=> dat_o[2:1] == {$past(trip_o), $past(start_o)})
    else $error("status bits differ from outputs");
  chk_start_cause: assert property ($rose(start_o) |-> $past(meas_valid_i, 3))
    else $error("start without measurement");
  chk_trip_started: assert property (trip_o |-> start_o) else $error("trip without start");
  chk_trip_late: assert property ($rose(start_o) |-> !trip_o) else $error("trip with start");
  chk_release_both: assert property ($fell(trip_o) |-> !start_o) else $error("trip dropped alone");
endmodule // ueb_stage_assertions

bind ueb_stage ueb_stage_assertions i_ueb_stage_assertions (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .dat_o, .ack_o, .meas_valid_i, .start_o, .trip_o);

// File: verification/ueb_meas_model.sv
`timescale 1ns/10ps
module ueb_meas_model (
  // clock and demanded power
  input  wire logic               clk_i,
  input  wire logic signed [15:0] p_i,
  input  wire logic signed [15:0] q_i,
  // phasors
  output logic                    meas_valid_o,
  output logic signed [15:0]      u_re_o,
  output logic signed [15:0]      u_im_o,
  output logic signed [15:0]      i1_re_o,
  output logic signed [15:0]      i1_im_o,
  output logic signed [15:0]      i3_re_o
);
  logic [1:0] cnt = 2'h0;
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
  end
  // strobe every fourth cycle, garbage between strobes
  assign meas_valid_o = (cnt == 2'h3);
  assign u_re_o       = meas_valid_o ? 16'sh0002 : 16'shfffd;
  assign u_im_o       = meas_valid_o ? 16'sh0000 : 16'shffff;
  assign i1_re_o      = meas_valid_o ? p_i : ~p_i;
  assign i1_im_o      = meas_valid_o ? -q_i : q_i;
  assign i3_re_o      = meas_valid_o ? 16'sh0001 : 16'shfffe;
endmodule // ueb_meas_model

// File: verification/test_under_excitation_stage.sv
`timescale 1ns/10ps
module test_under_excitation_stage;
  logic               clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]         adr_i = 8'h00;
  logic [3:0]         sel_i = 4'hf;
  logic [31:0]        dat_i = 32'h0000_0000, dat_o, e;
  logic               ack_o, start_o, trip_o, meas_valid_i;
  logic signed [15:0] p = 16'sh0000, q = 16'sh0000, u_re, u_im, i1_re, i1_im, i3_re, qin;
  logic [31:0]        expq[$];
  int                 fail_count = 0, total_checks = 0, cycles = 0;
  logic signed [15:0] qh[5] = '{16'shff9c, 16'shff9c, 16'shff9c, 16'sh012c, 16'sh012c};
  logic signed [15:0] pt[5] = '{16'sh0321, 16'sh0001, 16'sh0321, 16'sh0321, 16'sh0321};
  logic signed [15:0] qt[5] = '{16'shfed4, 16'shfed4, 16'shffce, 16'sh0064, 16'shfff6};
  logic [4:0]         ar = 5'h11;

  ueb_meas_model i_ueb_meas_model (.clk_i, .p_i(p), .q_i(q), .meas_valid_o(meas_valid_i), .u_re_o(u_re),
    .u_im_o(u_im), .i1_re_o(i1_re), .i1_im_o(i1_im), .i3_re_o(i3_re));
  ueb_stage #(.TICK_CYCLES(20)) i_ueb_stage (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .meas_valid_i, .u12_re_i(u_re), .u12_im_i(u_im), .u23_re_i(u_re), .u23_im_i(u_im),
    .i1_re_i(i1_re), .i1_im_i(i1_im), .i3_re_i(i3_re), .i3_im_i(u_im), .start_o, .trip_o);

  always #25 clk_i = ~clk_i;

  task automatic test_done;
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one classic bus cycle, reads note their expected data
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w)
      expq.push_back(d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, w ? d : 32'h0000_0000};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    {cyc_i, stb_i} <= 2'b00;
  endtask

  task automatic hold(input logic signed [15:0] v, input int n);
    q <= v;
    repeat (n) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done;
    end
  end

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      e = expq.size() > 0 ? expq.pop_front() : 32'hxxxx_xxxx;
      total_checks++;
      if (dat_o !== e) begin
        fail_count++;
        $display("unexpected read at %0t: got %h expected %h", $time, dat_o, e);
      end
      if (adr_i == 8'h14 && {trip_o, start_o} !== e[2:1]) begin
        fail_count++;
        $display("unexpected pins at %0t: got %h expected %h", $time, {trip_o, start_o}, e[2:1]);
      end
    end
  end

  initial begin
    void'($urandom(32'h448d));
    qin = 16'shfda8 - 16'($urandom_range(299));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h00, 32'h0000_0001);
    wb(0, 8'h04, 32'h0000_fe0c);
    wb(0, 8'h08, 32'h0000_fe0c);
    wb(0, 8'h0c, 32'h0000_03e8);
    wb(0, 8'h10, 32'h0000_0000);
    wb(1, 8'h14, 32'h0000_0007);
    wb(0, 8'h14, 32'h0000_0000);
    wb(0, 8'h20, 32'h0000_0000);
    wb(1, 8'h00, 32'h0000_0101);
    for (int k = 0; k < 5; k++) begin
      wb(1, 8'h08, {16'h0000, qh[k]});
      p <= pt[k];
      hold(qt[k], 40);
      wb(0, 8'h14, {30'h0000_0000, ar[k], ar[k]});
      wb(0, 8'h18, {pt[k] - 16'sh0001, qt[k]});
    end
    hold(16'sh0064, 2);
    wb(1, 8'h0c, 32'h0000_0004);
    wb(1, 8'h10, 32'h0000_0002);
    hold(16'sh0064, 100);
    hold(qin, 70);
    wb(0, 8'h14, 32'h0000_0003);
    hold(16'sh0064, 30);
    hold(qin, 60);
    wb(0, 8'h14, 32'h0000_0007);
    hold(16'sh0064, 100);
    wb(0, 8'h14, 32'h0000_0000);
    hold(qin, 50);
    wb(0, 8'h14, 32'h0000_0003);
    wb(1, 8'h00, 32'h0000_0100);
    wb(0, 8'h14, 32'h0000_0000);
    sel_i <= 4'h2;
    wb(1, 8'h04, 32'h0000_1234);
    sel_i <= 4'hf;
    wb(0, 8'h04, 32'h0000_120c);
    test_done;
  end
endmodule // test_under_excitation_stage
